// *** verilog/sdram_command_init_mode.sv ***
`timescale 1ns/1ps
// Summary of operation
// - commands decoded only from select, strobes and address bit 10 sampled at rising clock edge
// - strobe patterns decode to activate, precharge, read, write, mode set, stop, refresh
// - clock gate previous and current levels select normal, refresh, suspend, power-down
// - bank commands check and change only the bank chosen by bank select, except precharge all, which closes every bank
// - clock gate falling during a burst gives clock suspend, or self refresh on a refresh with all banks closed, never power-down
// - mode register holds no defined value until the controller programs it
// - a later mode set replaces the whole register
// - row, column and write strobes low load mode register from address
// - mode register holds burst length, burst order, read latency, operation mode
// - burst length on bits 2..0: 1,2,4,8 words, 111 full page sequential only
// - bit 3 selects burst order; bits 6..4 give read latency two or three
// - bits 12..7 select burst writes or single-location writes
// - burst column wraps to start of its aligned block
module sdram_command_init_mode (
  input  wire logic                             clk_sys,
  input  wire logic                             sys_rst,
  input  wire logic                             clock_gate,
  input  wire logic                             device_select_n,
  input  wire logic                             row_strobe_n,
  input  wire logic                             column_strobe_n,
  input  wire logic                             write_strobe_n,
  input  wire logic                             byte_mask,
  input  wire logic                             bank_sel_lo,
  input  wire logic                             bank_sel_hi,
  input  wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr_bus,
  output sdram_cmd_pkg::cmd_type                cmd,
  output logic                                  cmd_accepted,
  output logic                                  cmd_illegal,
  output sdram_cmd_pkg::pwr_type                pwr_state,
  output logic [sdram_cmd_pkg::NUM_BANKS-1:0]   bank_active,
  output logic                                  mode_valid,
  output sdram_cmd_pkg::mode_type               operating_mode_setting,
  output logic                                  mode_reserved,
  output logic                                  burst_busy,
  output logic                                  burst_is_write,
  output logic [sdram_cmd_pkg::COL_W-1:0]       burst_column,
  output logic                                  data_enable
);

  sdram_cmd_pkg::pins_type pins;
  sdram_cmd_pkg::cmd_type  dec;
  logic                    gate_prev;
  logic                    gate_now;
  logic [1:0]              bank;
  logic                    bank_ok;
  logic                    mode_ok;
  logic                    all_idle;
  logic                    frozen;
  logic [sdram_cmd_pkg::COL_W-1:0] burst_left;
  logic [sdram_cmd_pkg::COL_W-1:0] len_words;
  logic                    start_burst;
  logic                    advance;
  logic                    auto_close;
  logic [1:0]              close_bank;

  // decode the strobe pattern into a command
  function automatic sdram_cmd_pkg::cmd_type decode(input sdram_cmd_pkg::pins_type p);
    logic [2:0] s;
    s = {p.row_strobe_n, p.column_strobe_n, p.write_strobe_n};
    if (p.device_select_n) begin
      decode = sdram_cmd_pkg::CMD_DESELECT;
    end else begin
      unique case (s)
        sdram_cmd_pkg::STB_ACTIVATE:  decode = sdram_cmd_pkg::CMD_ACTIVATE;
        sdram_cmd_pkg::STB_PRECHARGE: decode = p.addr_bus[10] ? sdram_cmd_pkg::CMD_PRECHARGE_ALL
                                                              : sdram_cmd_pkg::CMD_PRECHARGE;
        sdram_cmd_pkg::STB_WRITE:     decode = p.addr_bus[10] ? sdram_cmd_pkg::CMD_WRITE_AP
                                                              : sdram_cmd_pkg::CMD_WRITE;
        sdram_cmd_pkg::STB_READ:      decode = p.addr_bus[10] ? sdram_cmd_pkg::CMD_READ_AP
                                                              : sdram_cmd_pkg::CMD_READ;
        sdram_cmd_pkg::STB_MODE_SET:  decode = sdram_cmd_pkg::CMD_MODE_SET;
        sdram_cmd_pkg::STB_NOP:       decode = sdram_cmd_pkg::CMD_NOP;
        sdram_cmd_pkg::STB_STOP:      decode = sdram_cmd_pkg::CMD_BURST_STOP;
        sdram_cmd_pkg::STB_REFRESH:   decode = sdram_cmd_pkg::CMD_REFRESH;
      endcase
    end
  endfunction

  // burst length code to word count; zero means full page
  function automatic logic [sdram_cmd_pkg::COL_W-1:0] words(input logic [2:0] code);
    unique case (code)
      sdram_cmd_pkg::BL_ONE:   words = sdram_cmd_pkg::COL_W'(1);
      sdram_cmd_pkg::BL_TWO:   words = sdram_cmd_pkg::COL_W'(2);
      sdram_cmd_pkg::BL_FOUR:  words = sdram_cmd_pkg::COL_W'(4);
      sdram_cmd_pkg::BL_EIGHT: words = sdram_cmd_pkg::COL_W'(8);
      default:                 words = '0;
    endcase
  endfunction

  // capture every pin at the rising edge; the host is on this clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins     <= '{device_select_n: 1'b1, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                    write_strobe_n: 1'b1, byte_mask: 1'b1, default: '0};
      gate_now <= 1'b1;
    end else begin
      pins     <= '{device_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
                    byte_mask, {bank_sel_hi, bank_sel_lo}, addr_bus};
      gate_now <= clock_gate;
    end
  end

  // previous gate level, one clock before the command
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gate_prev <= 1'b1;
    end else begin
      gate_prev <= gate_now;
    end
  end

  assign dec      = decode(pins);
  assign bank     = pins.bank_sel;
  assign all_idle = (bank_active == '0);
  assign frozen   = (pwr_state != sdram_cmd_pkg::PWR_NORMAL) || !gate_prev;
  assign len_words = words(operating_mode_setting.burst_len_field);

  // legality against the selected bank's state; mode set and refresh against all banks
  always_comb begin
    bank_ok = 1'b1;
    unique case (dec)
      sdram_cmd_pkg::CMD_ACTIVATE:  bank_ok = !bank_active[bank] && mode_valid;
      sdram_cmd_pkg::CMD_WRITE, sdram_cmd_pkg::CMD_WRITE_AP,
      sdram_cmd_pkg::CMD_READ, sdram_cmd_pkg::CMD_READ_AP:
                                    bank_ok = bank_active[bank] && mode_valid;
      sdram_cmd_pkg::CMD_MODE_SET, sdram_cmd_pkg::CMD_REFRESH:
                                    bank_ok = all_idle;
      default:                      bank_ok = 1'b1;
    endcase
  end

  assign cmd_accepted = !frozen && bank_ok && dec != sdram_cmd_pkg::CMD_DESELECT
                        && dec != sdram_cmd_pkg::CMD_NOP;
  assign cmd_illegal  = !frozen && !bank_ok;
  assign cmd          = dec;

  // power state from previous and current gate levels
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state <= sdram_cmd_pkg::PWR_NORMAL;
    end else begin
      unique case (pwr_state)
        sdram_cmd_pkg::PWR_NORMAL: begin
          if (gate_prev && !gate_now) begin
            if (dec == sdram_cmd_pkg::CMD_REFRESH && all_idle) begin
              pwr_state <= sdram_cmd_pkg::PWR_SELF_REFRESH;
            end else if (burst_busy) begin
              pwr_state <= sdram_cmd_pkg::PWR_SUSPEND;
            end else begin
              pwr_state <= sdram_cmd_pkg::PWR_POWER_DOWN;
            end
          end
        end
        sdram_cmd_pkg::PWR_SUSPEND: begin
          if (!gate_prev && gate_now) pwr_state <= sdram_cmd_pkg::PWR_NORMAL;
        end
        default: begin
          if (!gate_prev && gate_now && (dec == sdram_cmd_pkg::CMD_DESELECT ||
              dec == sdram_cmd_pkg::CMD_NOP)) begin
            pwr_state <= sdram_cmd_pkg::PWR_NORMAL;
          end
        end
      endcase
    end
  end

  // per-bank open/closed tracking; a command in the last beat of an auto-close burst must not lose the close
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bank_active <= '0;
    end else begin
      if (burst_busy && burst_left == sdram_cmd_pkg::COL_W'(1) && advance && auto_close) begin
        bank_active[close_bank] <= 1'b0;
      end
      if (cmd_accepted) begin
        if (dec == sdram_cmd_pkg::CMD_ACTIVATE) bank_active[bank] <= 1'b1;
        if (dec == sdram_cmd_pkg::CMD_PRECHARGE) bank_active[bank] <= 1'b0;
        if (dec == sdram_cmd_pkg::CMD_PRECHARGE_ALL) bank_active <= '0;
      end
    end
  end

  // mode register: undefined until first mode set, whole word replaced
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_valid <= 1'b0;
    end else if (cmd_accepted && dec == sdram_cmd_pkg::CMD_MODE_SET) begin
      mode_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!sys_rst && cmd_accepted && dec == sdram_cmd_pkg::CMD_MODE_SET) begin
      operating_mode_setting <= pins.addr_bus[sdram_cmd_pkg::OPM_MSB:sdram_cmd_pkg::BL_LSB];
    end
  end

  // reserved codes flagged: latency, length, page with interleave, op mode
  always_comb begin
    mode_ok = (operating_mode_setting.read_latency_field == sdram_cmd_pkg::CL_TWO ||
               operating_mode_setting.read_latency_field == sdram_cmd_pkg::CL_THREE);
    if (operating_mode_setting.burst_len_field == sdram_cmd_pkg::BL_PAGE) begin
      mode_ok = mode_ok && !operating_mode_setting.burst_order_bit;
    end else if (len_words == '0) begin
      mode_ok = 1'b0;
    end
    if (operating_mode_setting.op_mode != sdram_cmd_pkg::OPM_BURST_WR &&
        operating_mode_setting.op_mode != sdram_cmd_pkg::OPM_SINGLE_WR) begin
      mode_ok = 1'b0;
    end
  end
  assign mode_reserved = mode_valid && !mode_ok;

  // burst tracking; frozen while suspended
  assign start_burst = cmd_accepted && (dec == sdram_cmd_pkg::CMD_READ || dec == sdram_cmd_pkg::CMD_READ_AP ||
                       dec == sdram_cmd_pkg::CMD_WRITE || dec == sdram_cmd_pkg::CMD_WRITE_AP);
  assign advance     = burst_busy && !frozen;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      burst_busy     <= 1'b0;
      burst_is_write <= 1'b0;
      burst_left     <= '0;
      auto_close     <= 1'b0;
      close_bank     <= '0;
    end else if (start_burst) begin
      burst_busy     <= 1'b1;
      burst_is_write <= pins.write_strobe_n == 1'b0;
      auto_close     <= pins.addr_bus[10];
      close_bank     <= bank;
      // single-location write mode shortens write bursts to one word
      if (!pins.write_strobe_n && operating_mode_setting.op_mode == sdram_cmd_pkg::OPM_SINGLE_WR) begin
        burst_left   <= sdram_cmd_pkg::COL_W'(1);
      end else begin
        burst_left   <= len_words;
      end
    end else if (cmd_accepted && dec == sdram_cmd_pkg::CMD_BURST_STOP) begin
      burst_busy     <= 1'b0;
    end else if (advance) begin
      burst_left     <= burst_left - sdram_cmd_pkg::COL_W'(1);
      if (burst_left == sdram_cmd_pkg::COL_W'(1)) burst_busy <= 1'b0;
    end
  end

  // data path enable follows byte mask during a burst
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      data_enable <= 1'b0;
    end else begin
      data_enable <= burst_busy && !frozen && !pins.byte_mask;
    end
  end

  burst_column_gen #(
    .COL_W (sdram_cmd_pkg::COL_W)
  ) u_col (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .start           (start_burst),
    .advance         (advance),
    .start_col       ({pins.addr_bus[11], pins.addr_bus[9:0]}), // column skips the auto-close bit
    .burst_len_field (operating_mode_setting.burst_len_field),
    .burst_order_bit (operating_mode_setting.burst_order_bit),
    .column          (burst_column)
  );

  // a gate fall during a burst, unless a refresh, always enters suspend
  chk_suspend_from_burst: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pwr_state == sdram_cmd_pkg::PWR_NORMAL && gate_prev && !gate_now && burst_busy &&
     dec != sdram_cmd_pkg::CMD_REFRESH) |=> pwr_state == sdram_cmd_pkg::PWR_SUSPEND)
    else $error("gate fall in burst did not suspend");

  chk_mode_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_accepted && dec == sdram_cmd_pkg::CMD_MODE_SET) |=>
    operating_mode_setting == $past(pins.addr_bus) && mode_valid)
    else $error("mode register not loaded");

  chk_activate_bank: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_accepted && dec == sdram_cmd_pkg::CMD_ACTIVATE) |=> bank_active[$past(bank)])
    else $error("activate did not open selected bank");

  chk_no_act_unset: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !mode_valid |-> !(cmd_accepted && dec == sdram_cmd_pkg::CMD_ACTIVATE))
    else $error("activate accepted before mode set");

  // a suspended burst holds its column
  sequence suspended_burst;
    pwr_state == sdram_cmd_pkg::PWR_SUSPEND && burst_busy;
  endsequence

  chk_suspend_holds_col: assert property (@(posedge clk_sys) disable iff (sys_rst)
    suspended_burst |=> $stable(burst_column))
    else $error("burst column moved while suspended");

  chk_precharge_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cmd_accepted && dec == sdram_cmd_pkg::CMD_PRECHARGE_ALL) |=> bank_active == '0)
    else $error("precharge all left a bank open");

endmodule

// *** verilog/sdram_cmd_pkg.sv ***
package sdram_cmd_pkg;

  localparam int ADDR_W     = 13;
  localparam int BANK_W     = 2;
  localparam int NUM_BANKS  = 4;
  localparam int COL_W      = 11;

  // mode register field positions
  localparam int BL_LSB     = 0;
  localparam int BL_MSB     = 2;
  localparam int BT_BIT     = 3;
  localparam int CL_LSB     = 4;
  localparam int CL_MSB     = 6;
  localparam int OPM_LSB    = 7;
  localparam int OPM_MSB    = 12;

  // burst length codes
  localparam logic [2:0] BL_ONE   = 3'h0;
  localparam logic [2:0] BL_TWO   = 3'h1;
  localparam logic [2:0] BL_FOUR  = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE  = 3'h7;

  // read latency codes
  localparam logic [2:0] CL_TWO   = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;

  // operation mode codes
  localparam logic [5:0] OPM_BURST_WR  = 6'h00;
  localparam logic [5:0] OPM_SINGLE_WR = 6'h01;

  // strobe patterns {row, column, write}, active low
  localparam logic [2:0] STB_ACTIVATE  = 3'h3;
  localparam logic [2:0] STB_PRECHARGE = 3'h2;
  localparam logic [2:0] STB_WRITE     = 3'h4;
  localparam logic [2:0] STB_READ      = 3'h5;
  localparam logic [2:0] STB_MODE_SET  = 3'h0;
  localparam logic [2:0] STB_NOP       = 3'h7;
  localparam logic [2:0] STB_STOP      = 3'h6;
  localparam logic [2:0] STB_REFRESH   = 3'h1;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_PRECHARGE, CMD_PRECHARGE_ALL,
    CMD_WRITE, CMD_WRITE_AP, CMD_READ, CMD_READ_AP, CMD_MODE_SET,
    CMD_BURST_STOP, CMD_REFRESH
  } cmd_type;

  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_SELF_REFRESH, PWR_SUSPEND, PWR_POWER_DOWN
  } pwr_type;

  // sampled command pins
  typedef struct packed {
    logic              device_select_n;
    logic              row_strobe_n;
    logic              column_strobe_n;
    logic              write_strobe_n;
    logic              byte_mask;
    logic [BANK_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr_bus;
  } pins_type;

  // mode register contents
  typedef struct packed {
    logic [5:0] op_mode;
    logic [2:0] read_latency_field;
    logic       burst_order_bit;
    logic [2:0] burst_len_field;
  } mode_type;

endpackage

// *** verilog/burst_column_gen.sv ***
`timescale 1ns/1ps
// column sequencer for one burst: wraps within its aligned block
module burst_column_gen #(
  parameter int COL_W = sdram_cmd_pkg::COL_W
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic             advance,
  input  wire logic [COL_W-1:0] start_col,
  input  wire logic [2:0]       burst_len_field,
  input  wire logic             burst_order_bit,
  output logic      [COL_W-1:0] column
);

  logic [COL_W-1:0] base_col;
  logic [COL_W-1:0] count;
  logic [COL_W-1:0] wrap_mask;
  logic [COL_W-1:0] next_seq;

  // block mask from burst length; full page wraps over the whole row
  always_comb begin
    unique case (burst_len_field)
      sdram_cmd_pkg::BL_TWO:   wrap_mask = COL_W'(1);
      sdram_cmd_pkg::BL_FOUR:  wrap_mask = COL_W'(3);
      sdram_cmd_pkg::BL_EIGHT: wrap_mask = COL_W'(7);
      sdram_cmd_pkg::BL_PAGE:  wrap_mask = '1;
      default:                 wrap_mask = '0;
    endcase
  end

  // sequential adds, interleaved xors the offset inside the block
  always_comb begin
    if (burst_order_bit && burst_len_field != sdram_cmd_pkg::BL_PAGE) begin
      next_seq = (base_col & ~wrap_mask) | ((base_col ^ (count + COL_W'(1))) & wrap_mask);
    end else begin
      next_seq = (base_col & ~wrap_mask) | ((base_col + count + COL_W'(1)) & wrap_mask);
    end
  end

  // column register and offset counter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      base_col <= '0;
      count    <= '0;
      column   <= '0;
    end else if (start) begin
      base_col <= start_col;
      count    <= '0;
      column   <= start_col;
    end else if (advance) begin
      count    <= count + COL_W'(1);
      column   <= next_seq;
    end
  end

endmodule

// *** bench/host_ctrl_model.sv ***
`timescale 1ns/1ps
// controller side of the command pins and clock gate
module host_ctrl_model (
  output sdram_cmd_pkg::pins_type pins,
  output logic                    clock_gate
);
  // power-up: no-op on the command pins, mask and gate high
  initial begin
    pins = {1'b0, sdram_cmd_pkg::STB_NOP, 1'b1, 2'h0, 13'h0000};
    clock_gate = 1'b1;
  end
  // one command, sampled at the next rising edge; mode set always on bank 0
  task automatic put(input logic cs_n, input logic [2:0] stb, input logic [1:0] bk, input logic [12:0] a,
                     input logic gate, input logic mask);
    pins <= {cs_n, stb, mask, (stb == sdram_cmd_pkg::STB_MODE_SET) ? 2'h0 : bk, a};
    clock_gate <= gate;
  endtask
  // no-op with mask high; unheld address and bank lines show a changing pattern
  task automatic nop(input logic gate);
    pins <= {1'b0, sdram_cmd_pkg::STB_NOP, 1'b1, ~pins.bank_sel, ~pins.addr_bus};
    clock_gate <= gate;
  endtask
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  localparam int INIT_WAIT = 64;  // power-up pause, shortened from 50000 cycles
  logic                    clk_sys, sys_rst, clock_gate;
  logic                    cmd_accepted, cmd_illegal, mode_valid, mode_reserved;
  logic                    burst_busy, burst_is_write, data_enable;
  logic [3:0]              bank_active;
  logic [10:0]             burst_column;
  sdram_cmd_pkg::pins_type pins;
  sdram_cmd_pkg::cmd_type  cmd;
  sdram_cmd_pkg::pwr_type  pwr_state, m_pwr;
  sdram_cmd_pkg::mode_type operating_mode_setting;
  logic [3:0]              m_banks;
  logic                    m_valid, m_gate;
  logic [12:0]             m_mode;
  logic [9:0]              cols[$];
  int                      mismatches = 0, n_tests = 0, seed = 98;

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  host_ctrl_model host (.pins, .clock_gate);

  sdram_command_init_mode dut (
    .clk_sys, .sys_rst, .clock_gate, .device_select_n(pins.device_select_n),
    .row_strobe_n(pins.row_strobe_n), .column_strobe_n(pins.column_strobe_n),
    .write_strobe_n(pins.write_strobe_n), .byte_mask(pins.byte_mask), .bank_sel_lo(pins.bank_sel[0]),
    .bank_sel_hi(pins.bank_sel[1]), .addr_bus(pins.addr_bus), .cmd, .cmd_accepted, .cmd_illegal,
    .pwr_state, .bank_active, .mode_valid, .operating_mode_setting, .mode_reserved, .burst_busy,
    .burst_is_write, .burst_column, .data_enable
  );

  // records each new burst column while a burst runs; frozen columns are not repeated
  always @(posedge clk_sys) begin
    if (burst_busy === 1'b1 && (cols.size() == 0 || cols[$] !== burst_column[9:0])) cols.push_back(burst_column[9:0]);
  end

  // expected decode of one set of pins
  function automatic sdram_cmd_pkg::cmd_type decode(input logic cs_n, input logic [2:0] s, input logic ap);
    if (cs_n) return sdram_cmd_pkg::CMD_DESELECT;
    case (s)
      sdram_cmd_pkg::STB_ACTIVATE:  return sdram_cmd_pkg::CMD_ACTIVATE;
      sdram_cmd_pkg::STB_PRECHARGE: return ap ? sdram_cmd_pkg::CMD_PRECHARGE_ALL : sdram_cmd_pkg::CMD_PRECHARGE;
      sdram_cmd_pkg::STB_WRITE:     return ap ? sdram_cmd_pkg::CMD_WRITE_AP : sdram_cmd_pkg::CMD_WRITE;
      sdram_cmd_pkg::STB_READ:      return ap ? sdram_cmd_pkg::CMD_READ_AP : sdram_cmd_pkg::CMD_READ;
      sdram_cmd_pkg::STB_MODE_SET:  return sdram_cmd_pkg::CMD_MODE_SET;
      sdram_cmd_pkg::STB_STOP:      return sdram_cmd_pkg::CMD_BURST_STOP;
      sdram_cmd_pkg::STB_REFRESH:   return sdram_cmd_pkg::CMD_REFRESH;
      default:                      return sdram_cmd_pkg::CMD_NOP;
    endcase
  endfunction

  // one command then a no-op; the model predicts decode, refusal and the state that follows
  task automatic do_cmd(input logic cs_n, input logic [2:0] s, input logic [1:0] bk, input logic [12:0] a,
                        input logic gate);
    sdram_cmd_pkg::cmd_type ec;
    logic ill, go, er;
    logic [1:0] b;
    b = (s == sdram_cmd_pkg::STB_MODE_SET) ? 2'h0 : bk;
    ec = decode(cs_n, s, a[10]);
    go = m_gate && gate && m_pwr == sdram_cmd_pkg::PWR_NORMAL;
    ill = 1'b0;
    if (ec == sdram_cmd_pkg::CMD_ACTIVATE) ill = m_banks[b] || !m_valid;
    if (ec inside {[sdram_cmd_pkg::CMD_WRITE:sdram_cmd_pkg::CMD_READ_AP]}) ill = !m_banks[b] || !m_valid;
    if (ec == sdram_cmd_pkg::CMD_MODE_SET || ec == sdram_cmd_pkg::CMD_REFRESH) ill = m_banks != 4'h0;
    @(posedge clk_sys);
    host.put(cs_n, s, bk, a, gate, 1'($random(seed)));
    @(posedge clk_sys);
    host.nop(gate);
    #1;
    if (go) begin
      `CHK(cmd, ec)
      `CHK(cmd_illegal, ill)
      if (ec != sdram_cmd_pkg::CMD_NOP && ec != sdram_cmd_pkg::CMD_DESELECT) `CHK(cmd_accepted, !ill)
      if (!ill && ec == sdram_cmd_pkg::CMD_ACTIVATE) m_banks[b] = 1'b1;
      if (!ill && ec == sdram_cmd_pkg::CMD_PRECHARGE) m_banks[b] = 1'b0;
      if (ec == sdram_cmd_pkg::CMD_PRECHARGE_ALL) m_banks = 4'h0;
      if (!ill && ec == sdram_cmd_pkg::CMD_MODE_SET) begin
        m_mode = a;
        m_valid = 1'b1;
      end
    end
    if (m_pwr == sdram_cmd_pkg::PWR_NORMAL && m_gate && !gate)
      m_pwr = (ec == sdram_cmd_pkg::CMD_REFRESH) ? sdram_cmd_pkg::PWR_SELF_REFRESH : sdram_cmd_pkg::PWR_POWER_DOWN;
    else if (!m_gate && gate) m_pwr = sdram_cmd_pkg::PWR_NORMAL;
    m_gate = gate;
    @(posedge clk_sys);
    #1;
    `CHK(pwr_state, m_pwr)
    `CHK(bank_active, m_banks)
    `CHK(mode_valid, m_valid)
    if (m_valid) begin
      `CHK(operating_mode_setting, m_mode)
      er = !(m_mode[6:4] inside {3'h2, 3'h3}) || m_mode[12:7] > 6'h01;
      er = er || m_mode[2:0] inside {3'h4, 3'h5, 3'h6} || (m_mode[2:0] == 3'h7 && m_mode[3]);
      `CHK(mode_reserved, er)
    end
  endtask

  // mode set, open a random bank, run one burst and compare its column order
  task automatic burst_case(input logic [2:0] blc, input logic ord, input logic [5:0] opm, input logic [2:0] s,
                            input logic ap, input logic susp);
    logic [1:0] bk;
    logic [9:0] c, e;
    int n, k;
    logic mk, m1, m2, bq;
    bk = 2'($random(seed));
    c = 10'($random(seed));
    n = (s == sdram_cmd_pkg::STB_WRITE && opm == sdram_cmd_pkg::OPM_SINGLE_WR) ? 1 : (1 << blc);
    do_cmd(1'b0, sdram_cmd_pkg::STB_MODE_SET, 2'h0, {opm, 2'h1, 1'($random(seed)), ord, blc}, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_ACTIVATE, bk, 13'($random(seed)), 1'b1);
    cols.delete();
    do_cmd(1'b0, s, bk, {2'h0, ap, c}, 1'b1);
    if (susp) begin
      repeat (4) begin
        @(posedge clk_sys);
        host.nop(1'b0);
      end
      #1;
      `CHK(pwr_state, sdram_cmd_pkg::PWR_SUSPEND)
    end
    k = 0;
    m1 = 1'b1;
    m2 = 1'b1;
    bq = 1'b1;
    // random mask during the burst; data enable follows the mask two edges later
    while (burst_busy !== 1'b0 && k < 300) begin
      mk = 1'($random(seed));
      @(posedge clk_sys);
      host.put(1'b0, sdram_cmd_pkg::STB_NOP, 2'h0, 13'h0000, 1'b1, mk);
      #1;
      if (!susp) `CHK(data_enable, bq && !m2)
      if (burst_busy === 1'b1) `CHK(burst_is_write, s == sdram_cmd_pkg::STB_WRITE)
      m2 = m1;
      m1 = mk;
      bq = burst_busy;
      k++;
    end
    `CHK(cols.size(), n)
    for (int i = 0; i < n && i < cols.size(); i++) begin
      e = ord ? (c ^ 10'(i)) : ((c & ~10'(n - 1)) | ((c + 10'(i)) & 10'(n - 1)));
      `CHK(cols[i], e)
    end
    repeat (4) begin
      @(posedge clk_sys);
      host.nop(1'b1);
    end
    if (ap) begin
      m_banks[bk] = 1'b0;
      `CHK(bank_active, m_banks)
    end
    do_cmd(1'b0, sdram_cmd_pkg::STB_PRECHARGE, bk, 13'h0000, 1'b1);
  endtask

  // prints the counts and the verdict, then ends the run
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    m_banks = 4'h0;
    m_valid = 1'b0;
    m_gate = 1'b1;
    m_pwr = sdram_cmd_pkg::PWR_NORMAL;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (INIT_WAIT) begin
      @(posedge clk_sys);
      host.nop(1'b1);
    end
    #1;
    `CHK(mode_valid, 1'b0)
    do_cmd(1'b0, sdram_cmd_pkg::STB_ACTIVATE, 2'h1, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_PRECHARGE, 2'h0, 13'h0400, 1'b1);
    repeat (8) do_cmd(1'b0, sdram_cmd_pkg::STB_REFRESH, 2'h0, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_MODE_SET, 2'h0, 13'h0023, 1'b1);
    $display("test init done");
    do_cmd(1'b0, sdram_cmd_pkg::STB_ACTIVATE, 2'h2, 13'($random(seed)), 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_READ, 2'h1, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_ACTIVATE, 2'h2, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_MODE_SET, 2'h0, 13'h0031, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_REFRESH, 2'h0, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_STOP, 2'h0, 13'h0000, 1'b1);
    do_cmd(1'b1, sdram_cmd_pkg::STB_MODE_SET, 2'h0, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_PRECHARGE, 2'h2, 13'h0000, 1'b1);
    $display("test decode done");
    for (int i = 0; i < 8; i++)
      do_cmd(1'b0, sdram_cmd_pkg::STB_MODE_SET, 2'h0,
             {6'(i == 7 ? 2 : i & 1), 3'(i), i[0], 3'(i == 3 ? 7 : i == 2 ? 4 : 1)}, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_MODE_SET, 2'h0, 13'h0027, 1'b1);
    $display("test mode fields done");
    do_cmd(1'b0, sdram_cmd_pkg::STB_NOP, 2'h0, 13'h0000, 1'b0);
    do_cmd(1'b0, sdram_cmd_pkg::STB_NOP, 2'h0, 13'h0000, 1'b1);
    do_cmd(1'b0, sdram_cmd_pkg::STB_REFRESH, 2'h0, 13'h0000, 1'b0);
    do_cmd(1'b1, sdram_cmd_pkg::STB_NOP, 2'h0, 13'h0000, 1'b1);
    $display("test power states done");
    for (int i = 0; i < 8; i++)
      burst_case(3'(i >> 1), i[0], sdram_cmd_pkg::OPM_BURST_WR,
                 ($random(seed) & 1) ? sdram_cmd_pkg::STB_WRITE : sdram_cmd_pkg::STB_READ, 1'b0, 1'b0);
    burst_case(3'h2, 1'b0, sdram_cmd_pkg::OPM_SINGLE_WR, sdram_cmd_pkg::STB_WRITE, 1'b0, 1'b0);
    burst_case(3'h2, 1'b1, sdram_cmd_pkg::OPM_SINGLE_WR, sdram_cmd_pkg::STB_READ, 1'b1, 1'b0);
    burst_case(3'h3, 1'b0, sdram_cmd_pkg::OPM_BURST_WR, sdram_cmd_pkg::STB_WRITE, 1'b1, 1'b0);
    burst_case(3'h3, 1'b1, sdram_cmd_pkg::OPM_BURST_WR, sdram_cmd_pkg::STB_READ, 1'b0, 1'b1);
    $display("test bursts done");
    report_and_stop();
  end

  // cuts a hang short at 20000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    mismatches++;
    report_and_stop();
  end
endmodule
